// ==== verilog/cfg_bank_map.svh ====
// Purpose: register indices, field positions and reset values of the config bank
// Assumes: byte address of a register is four times its index
// Notes:   definitions only
`ifndef CFG_BANK_MAP_SVH
`define CFG_BANK_MAP_SVH

// ----------------------------------------------------------------------------
// register indices
// ----------------------------------------------------------------------------
`define IDX_DSP        10'h06C
`define IDX_AGC        10'h070
`define IDX_INEN       10'h073
`define IDX_SLOT       10'h074
`define IDX_PWR        10'h075
`define IDX_VOL_BASE   7'h10
`define IDX_STAT       10'h090

// ----------------------------------------------------------------------------
// reset values and writable masks
// ----------------------------------------------------------------------------
`define RST_DSP        8'h40
`define RST_AGC        8'hE7
`define RST_INEN       8'hF0
`define RST_SLOT       8'h00
`define RST_PWR        8'h00
`define RST_VOL        8'hC9
`define MASK_DSP       8'hF8
`define MASK_PWR       8'hFC

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define DSP_GANG       7
`define DSP_BQ_HI      6
`define DSP_BQ_LO      5
`define DSP_SOFT       4
`define DSP_SEL        3
`define AGC_TGT_HI     7
`define AGC_TGT_LO     4
`define AGC_CEIL_HI    3
`define AGC_CEIL_LO    0
`define CEIL_MAX       4'hD
`define PWR_BIAS       7
`define PWR_CONV       6
`define PWR_SYNTH      5
`define PWR_LIVE       4
`define PWR_RNG_HI     3
`define PWR_RNG_LO     2

// ----------------------------------------------------------------------------
// bus answers
// ----------------------------------------------------------------------------
`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2

`endif

// ==== verilog/cfg_bank_pkg.sv ====
// Purpose: types shared by the config bank
// Assumes: nothing
// Notes:   none
`default_nettype none
package cfg_bank_pkg;

  typedef enum logic [1:0] {
    MODE_SLEEP,
    MODE_IDLE,
    MODE_ACTIVE
  } pwr_mode_t;

endpackage
`default_nettype wire

// ==== verilog/chan_slice.sv ====
// Purpose: one channel's volume pick, power state and output slot enable
// Assumes: all inputs on the same clock
// Notes:   outputs are registered
`timescale 1ns/1ns
`default_nettype none
`include "cfg_bank_map.svh"
module chan_slice (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // settings
  input  wire logic       gang,
  input  wire logic [7:0] first_vol,
  input  wire logic [7:0] own_vol,
  input  wire logic       conv_on,
  input  wire logic       in_en,
  input  wire logic       pdm_ok,
  input  wire logic       recording,
  input  wire logic       live_en,
  input  wire logic       in_range,
  input  wire logic       slot_en,
  // results
  output logic [7:0]      vol_reg,
  output logic            power_reg,
  output logic            oe_n_reg
);

  logic allowed;
  logic power_next;

  // ----------------------------------------------------------------------------
  // volume and slot drive
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      vol_reg <= `RST_VOL;
    end else begin
      vol_reg <= gang ? first_vol : own_vol;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      oe_n_reg <= 1'b1;
    end else begin
      oe_n_reg <= !slot_en;
    end
  end

  // ----------------------------------------------------------------------------
  // power
  // ----------------------------------------------------------------------------
  assign allowed = !recording || (live_en && in_range);

  always_comb begin
    if (!conv_on) begin
      power_next = 1'b0;
    end else if (allowed) begin
      power_next = in_en && pdm_ok;
    end else begin
      power_next = power_reg;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      power_reg <= 1'b0;
    end else begin
      power_reg <= power_next;
    end
  end

  // ----------------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------------
  chk_gang_copy: assert property (@(posedge clk) disable iff (!rst_n)
    gang |=> vol_reg == $past(first_vol))
    else $error("ganged volume not taken from channel one");
  chk_own_volume: assert property (@(posedge clk) disable iff (!rst_n)
    !gang |=> vol_reg == $past(own_vol))
    else $error("channel volume not its own");
  chk_slot_drive: assert property (@(posedge clk) disable iff (!rst_n)
    1'b1 |=> oe_n_reg == !$past(slot_en))
    else $error("slot enable not followed");
  chk_power_down: assert property (@(posedge clk) disable iff (!rst_n)
    !conv_on |=> !power_reg)
    else $error("channel powered with converter off");
  chk_live_hold: assert property (@(posedge clk) disable iff (!rst_n)
    (conv_on && recording && !(live_en && in_range)) |=> $stable(power_reg))
    else $error("channel power changed while recording");

endmodule // chan_slice
`default_nettype wire

// ==== verilog/cfg_bank.sv ====
// Purpose: AXI4-Lite config bank for processing, gain loop, channel enables,
//          output slots and power-up of a multichannel audio converter
// Assumes: one write and one read outstanding; 8-bit registers in low lanes, 10-bit status
// Notes:   channel n sits at bit 8-n of every per-channel field
`timescale 1ns/1ns
`default_nettype none
`include "cfg_bank_map.svh"
module cfg_bank (
  // clock and reset
  input  wire logic        REF_CLK,
  input  wire logic        ARST_N,
  // write address channel
  input  wire logic        AWVALID,
  output logic             AWREADY,
  input  wire logic [11:0] AWADDR,
  // write data channel
  input  wire logic        WVALID,
  output logic             WREADY,
  input  wire logic [31:0] WDATA,
  input  wire logic [3:0]  WSTRB,
  // write response channel
  output logic             BVALID,
  input  wire logic        BREADY,
  output logic [1:0]       BRESP,
  // read address channel
  input  wire logic        ARVALID,
  output logic             ARREADY,
  input  wire logic [11:0] ARADDR,
  // read data channel
  output logic             RVALID,
  input  wire logic        RREADY,
  output logic [31:0]      RDATA,
  output logic [1:0]       RRESP,
  // converter state
  input  wire logic        RECORDING,
  input  wire logic [3:0]  PDM_SELECTED,
  // processing settings
  output logic [1:0]       BIQUAD_COUNT,
  output logic             SOFT_STEP_OFF,
  output logic             GAIN_LOOP_SELECT,
  output logic [3:0]       GAIN_LOOP_TARGET_LEVEL,
  output logic [3:0]       GAIN_LOOP_GAIN_CEILING,
  output logic [63:0]      CH_VOLUME,
  // power and slots
  output logic             BIAS_POWER_ON,
  output logic             SYNTH_POWER_ON,
  output logic [7:0]       CH_POWER,
  output logic [7:0]       SLOT_OE_N
);

  logic                   aw_hold_reg;
  logic [11:0]            aw_addr_reg;
  logic                   w_hold_reg;
  logic [7:0]             w_data_reg;
  logic                   w_strb_reg;
  logic                   bvalid_reg;
  logic [1:0]             bresp_reg;
  logic                   rvalid_reg;
  logic [31:0]            rdata_reg;
  logic [1:0]             rresp_reg;
  logic                   wr_do;
  logic                   wr_en;
  logic [9:0]             wr_idx;
  logic [9:0]             rd_idx;
  logic [31:0]            rd_data_next;
  logic                   wr_dsp;
  logic                   wr_agc;
  logic                   wr_inen;
  logic                   wr_slot;
  logic                   wr_pwr;
  logic                   wr_vol;
  logic [7:0]             dsp_reg;
  logic [7:0]             agc_reg;
  logic [7:0]             inen_reg;
  logic [7:0]             slot_reg;
  logic [7:0]             pwr_reg;
  logic [7:0]             vol_reg [8];
  logic [7:0]             ch_power;
  cfg_bank_pkg::pwr_mode_t mode_reg;
  cfg_bank_pkg::pwr_mode_t mode_next;

  // ----------------------------------------------------------------------------
  // address map
  // ----------------------------------------------------------------------------
  function automatic logic is_mapped(input logic [9:0] idx);
    is_mapped = (idx == `IDX_DSP) || (idx == `IDX_AGC) || (idx == `IDX_INEN)
             || (idx == `IDX_SLOT) || (idx == `IDX_PWR) || (idx == `IDX_STAT)
             || (idx[9:3] == `IDX_VOL_BASE);
  endfunction

  // ----------------------------------------------------------------------------
  // write channels
  // ----------------------------------------------------------------------------
  assign AWREADY = !aw_hold_reg;
  assign WREADY  = !w_hold_reg;
  assign BVALID  = bvalid_reg;
  assign BRESP   = bresp_reg;
  assign wr_do   = aw_hold_reg && w_hold_reg && !bvalid_reg;
  assign wr_idx  = aw_addr_reg[11:2];
  assign wr_en   = wr_do && w_strb_reg;

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      aw_hold_reg <= 1'b0;
      aw_addr_reg <= 12'h000;
    end else if (AWVALID && !aw_hold_reg) begin
      aw_hold_reg <= 1'b1;
      aw_addr_reg <= AWADDR;
    end else if (wr_do) begin
      aw_hold_reg <= 1'b0;
    end
  end

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      w_hold_reg <= 1'b0;
      w_data_reg <= 8'h00;
      w_strb_reg <= 1'b0;
    end else if (WVALID && !w_hold_reg) begin
      w_hold_reg <= 1'b1;
      w_data_reg <= WDATA[7:0];
      w_strb_reg <= WSTRB[0];
    end else if (wr_do) begin
      w_hold_reg <= 1'b0;
    end
  end

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= `RESP_OKAY;
    end else if (wr_do) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= is_mapped(wr_idx) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (BREADY) begin
      bvalid_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------------
  // write decode
  // ----------------------------------------------------------------------------
  assign wr_dsp  = wr_en && (wr_idx == `IDX_DSP);
  assign wr_agc  = wr_en && (wr_idx == `IDX_AGC);
  assign wr_inen = wr_en && (wr_idx == `IDX_INEN);
  assign wr_slot = wr_en && (wr_idx == `IDX_SLOT);
  assign wr_pwr  = wr_en && (wr_idx == `IDX_PWR);
  assign wr_vol  = wr_en && (wr_idx[9:3] == `IDX_VOL_BASE);

  // ----------------------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------------------
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      dsp_reg <= `RST_DSP;
    end else if (wr_dsp) begin
      dsp_reg <= w_data_reg & `MASK_DSP;
    end
  end

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      agc_reg <= `RST_AGC;
    end else if (wr_agc) begin
      agc_reg <= w_data_reg;
    end
  end

  // extra channels need a pulse-density source before they may be enabled
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      inen_reg <= `RST_INEN;
    end else if (wr_inen) begin
      inen_reg <= w_data_reg & {4'hF, PDM_SELECTED};
    end
  end

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      slot_reg <= `RST_SLOT;
    end else if (wr_slot) begin
      slot_reg <= w_data_reg;
    end
  end

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      pwr_reg <= `RST_PWR;
    end else if (wr_pwr) begin
      pwr_reg <= w_data_reg & `MASK_PWR;
    end
  end

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      for (int k = 0; k < 8; k++) begin
        vol_reg[k] <= `RST_VOL;
      end
    end else if (wr_vol) begin
      vol_reg[wr_idx[2:0]] <= w_data_reg;
    end
  end

  // ----------------------------------------------------------------------------
  // channel slices
  // ----------------------------------------------------------------------------
  for (genvar i = 0; i < 8; i++) begin : g_chan
    logic pdm_ok;
    logic in_range;
    logic oe_n;
    if (i < 4) begin : g_analog
      assign pdm_ok = 1'b1;
    end else begin : g_pdm
      assign pdm_ok = PDM_SELECTED[7-i];
    end
    assign in_range = 4'(i) < ({1'b0, pwr_reg[`PWR_RNG_HI:`PWR_RNG_LO], 1'b0} + 4'h2);
    chan_slice i_chan_slice (
      .clk       (REF_CLK),
      .rst_n     (ARST_N),
      .gang      (dsp_reg[`DSP_GANG]),
      .first_vol (vol_reg[0]),
      .own_vol   (vol_reg[i]),
      .conv_on   (pwr_reg[`PWR_CONV]),
      .in_en     (inen_reg[7-i]),
      .pdm_ok    (pdm_ok),
      .recording (RECORDING),
      .live_en   (pwr_reg[`PWR_LIVE]),
      .in_range  (in_range),
      .slot_en   (slot_reg[7-i]),
      .vol_reg   (CH_VOLUME[8*(7-i) +: 8]),
      .power_reg (ch_power[7-i]),
      .oe_n_reg  (oe_n)
    );
    assign SLOT_OE_N[7-i] = oe_n;
  end

  // ----------------------------------------------------------------------------
  // settings out
  // ----------------------------------------------------------------------------
  assign BIQUAD_COUNT           = dsp_reg[`DSP_BQ_HI:`DSP_BQ_LO];
  assign SOFT_STEP_OFF          = dsp_reg[`DSP_SOFT];
  assign GAIN_LOOP_SELECT       = dsp_reg[`DSP_SEL];
  assign GAIN_LOOP_TARGET_LEVEL = agc_reg[`AGC_TGT_HI:`AGC_TGT_LO];
  // reserved ceiling codes stay readable but the loop sees the top legal code
  assign GAIN_LOOP_GAIN_CEILING = (agc_reg[`AGC_CEIL_HI:`AGC_CEIL_LO] > `CEIL_MAX) ?
                                  `CEIL_MAX : agc_reg[`AGC_CEIL_HI:`AGC_CEIL_LO];
  assign BIAS_POWER_ON          = pwr_reg[`PWR_BIAS];
  assign SYNTH_POWER_ON         = pwr_reg[`PWR_SYNTH];
  assign CH_POWER               = ch_power;

  // ----------------------------------------------------------------------------
  // power mode status
  // ----------------------------------------------------------------------------
  always_comb begin
    if (|ch_power) begin
      mode_next = cfg_bank_pkg::MODE_ACTIVE;
    end else if (|pwr_reg[`PWR_BIAS:`PWR_SYNTH]) begin
      mode_next = cfg_bank_pkg::MODE_IDLE;
    end else begin
      mode_next = cfg_bank_pkg::MODE_SLEEP;
    end
  end

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      mode_reg <= cfg_bank_pkg::MODE_SLEEP;
    end else begin
      mode_reg <= mode_next;
    end
  end

  // ----------------------------------------------------------------------------
  // read channels
  // ----------------------------------------------------------------------------
  assign rd_idx  = ARADDR[11:2];
  assign ARREADY = !rvalid_reg;
  assign RVALID  = rvalid_reg;
  assign RDATA   = rdata_reg;
  assign RRESP   = rresp_reg;

  always_comb begin
    rd_data_next = 32'h00000000;
    if (rd_idx == `IDX_DSP) begin
      rd_data_next[7:0] = dsp_reg;
    end else if (rd_idx == `IDX_AGC) begin
      rd_data_next[7:0] = agc_reg;
    end else if (rd_idx == `IDX_INEN) begin
      rd_data_next[7:0] = inen_reg;
    end else if (rd_idx == `IDX_SLOT) begin
      rd_data_next[7:0] = slot_reg;
    end else if (rd_idx == `IDX_PWR) begin
      rd_data_next[7:0] = pwr_reg;
    end else if (rd_idx[9:3] == `IDX_VOL_BASE) begin
      rd_data_next[7:0] = vol_reg[rd_idx[2:0]];
    end else if (rd_idx == `IDX_STAT) begin
      rd_data_next[9:0] = {mode_reg, ch_power};
    end
  end

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h00000000;
      rresp_reg  <= `RESP_OKAY;
    end else if (ARVALID && !rvalid_reg) begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= rd_data_next;
      rresp_reg  <= is_mapped(rd_idx) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (RREADY) begin
      rvalid_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------------
  chk_biquad_write: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    wr_dsp |=> BIQUAD_COUNT == $past(w_data_reg[6:5]))
    else $error("biquad count not taken from write");
  chk_soft_gain_sel: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    wr_dsp |=> SOFT_STEP_OFF == $past(w_data_reg[4]) && GAIN_LOOP_SELECT == $past(w_data_reg[3]))
    else $error("soft step or gain loop select wrong");
  chk_agc_write: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    wr_agc |=> GAIN_LOOP_TARGET_LEVEL == $past(w_data_reg[7:4]) ##1 $stable(agc_reg) || wr_agc)
    else $error("gain loop register not written");
  chk_ceiling_clamp: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    GAIN_LOOP_GAIN_CEILING <= 4'hD)
    else $error("gain ceiling reached a reserved code");
  chk_pdm_gate: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    wr_inen |=> (inen_reg[3:0] & ~$past(PDM_SELECTED)) == 4'h0)
    else $error("extra channel enabled without a pulse-density source");
  chk_slot_write: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    wr_slot |=> ##1 SLOT_OE_N == ~$past(w_data_reg, 2))
    else $error("slot drive does not follow write");
  chk_power_bits: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    wr_pwr |=> BIAS_POWER_ON == $past(w_data_reg[7]) && SYNTH_POWER_ON == $past(w_data_reg[5]))
    else $error("bias or synth power wrong");
  chk_reserved_zero: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    dsp_reg[2:0] == 3'h0 && pwr_reg[1:0] == 2'h0)
    else $error("reserved bits set");
  chk_write_answer: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    wr_do |=> BVALID)
    else $error("write not answered");

endmodule // cfg_bank
`default_nettype wire

// ==== testbench/cfg_bank_bench.sv ====
// Purpose: self-checking bench for the config bank over AXI4-Lite
// Assumes: byte address is four times the register index
// Notes:   inputs change by non-blocking assignment at rising edges
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin bad_count++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module cfg_bank_bench;
  // ----------------
  // signals
  // ----------------
  logic        ref_clk = 1'b0;
  logic        arst_n, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, recording;
  logic        soft_off, loop_sel, bias_on, synth_on;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb, pdm_sel, tgt, ceil, k;
  logic [1:0]  bresp, rresp, biquad, c;
  logic [63:0] ch_vol;
  logic [7:0]  ch_pwr, slot_oe_n;
  logic [11:0] reg_addr [5] = '{12'h1B0, 12'h1C0, 12'h1CC, 12'h1D0, 12'h1D4};
  logic [7:0]  reg_rst  [5] = '{8'h40, 8'hE7, 8'hF0, 8'h00, 8'h00};
  int          bad_count = 0;
  int          n_compared = 0;
  int          i;

  always #5 ref_clk = ~ref_clk;

  cfg_bank i_cfg_bank (.REF_CLK(ref_clk), .ARST_N(arst_n),
    .AWVALID(awvalid), .AWREADY(awready), .AWADDR(awaddr),
    .WVALID(wvalid), .WREADY(wready), .WDATA(wdata), .WSTRB(wstrb),
    .BVALID(bvalid), .BREADY(bready), .BRESP(bresp),
    .ARVALID(arvalid), .ARREADY(arready), .ARADDR(araddr),
    .RVALID(rvalid), .RREADY(rready), .RDATA(rdata), .RRESP(rresp),
    .RECORDING(recording), .PDM_SELECTED(pdm_sel), .BIQUAD_COUNT(biquad),
    .SOFT_STEP_OFF(soft_off), .GAIN_LOOP_SELECT(loop_sel),
    .GAIN_LOOP_TARGET_LEVEL(tgt), .GAIN_LOOP_GAIN_CEILING(ceil),
    .CH_VOLUME(ch_vol), .BIAS_POWER_ON(bias_on), .SYNTH_POWER_ON(synth_on),
    .CH_POWER(ch_pwr), .SLOT_OE_N(slot_oe_n));

  // ----------------
  // tasks
  // ----------------
  // handshakes are judged at the falling edge, where inputs already hold
  // the values that the next rising edge will sample
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
    logic ta, tw, tb;
    logic [1:0] got;
    @(posedge ref_clk);
    awaddr <= a; wdata <= {24'h0, d}; wstrb <= 4'hF;
    awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    tb = 1'b0;
    while (!tb) begin
      @(negedge ref_clk);
      ta = awvalid && awready; tw = wvalid && wready; tb = bvalid; got = bresp;
      @(posedge ref_clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    `CHK(got, er)
  endtask

  task automatic rd(input logic [11:0] a, input logic [9:0] ed, input logic [1:0] er);
    logic ta, tr;
    logic [31:0] gd;
    logic [1:0] gr;
    @(posedge ref_clk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    tr = 1'b0;
    while (!tr) begin
      @(negedge ref_clk);
      ta = arvalid && arready; tr = rvalid; gd = rdata; gr = rresp;
      @(posedge ref_clk);
      if (ta) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    `CHK(gd, {22'h0, ed})
    `CHK(gr, er)
  endtask

  task automatic settle();
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask

  task automatic final_report();
    $display("compared %0d, mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // ----------------
  // tests
  // ----------------
  initial begin
    arst_n = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0;
    rready = 1'b0; awaddr = 12'h0; araddr = 12'h0; wdata = 32'h0; wstrb = 4'h0;
    recording = 1'b0; pdm_sel = 4'hA;
    repeat (5) @(posedge ref_clk);
    arst_n <= 1'b1;
    for (i = 0; i < 5; i++) rd(reg_addr[i], reg_rst[i], 2'h0);
    rd(12'h240, 10'h000, 2'h0);
    `CHK({biquad, soft_off, loop_sel, tgt, ceil}, 12'h8E7)
    `CHK(slot_oe_n, 8'hFF)
    $display("test reset done");
    for (i = 0; i < 4; i++) begin
      c = i[1:0];
      wr(12'h1B0, {1'b0, c, c[0], c[1], 3'b111}, 2'h0);
      settle();
      rd(12'h1B0, {1'b0, c, c[0], c[1], 3'b000}, 2'h0);
      `CHK({biquad, soft_off, loop_sel}, {c, c[0], c[1]})
    end
    $display("test processing done");
    for (i = 0; i < 16; i++) begin
      k = i[3:0];
      wr(12'h1C0, {k, k}, 2'h0);
      settle();
      `CHK(tgt, k)
      `CHK(ceil, (k > 4'hD) ? 4'hD : k)
    end
    rd(12'h1C0, 8'hFF, 2'h0);
    $display("test gain loop done");
    wr(12'h1D0, 8'hA5, 2'h0);
    settle();
    `CHK(slot_oe_n, 8'h5A)
    rd(12'h1D0, 8'hA5, 2'h0);
    wr(12'h1CC, 8'hFF, 2'h0);
    rd(12'h1CC, 8'hFA, 2'h0);
    $display("test enables done");
    wr(12'h1D4, 8'hFF, 2'h0);
    settle();
    rd(12'h1D4, 8'hFC, 2'h0);
    `CHK({bias_on, synth_on, ch_pwr}, 10'h3FA)
    wr(12'h1D4, 8'h00, 2'h0);
    settle();
    `CHK({bias_on, synth_on, ch_pwr}, 10'h000)
    wr(12'h1D4, 8'h50, 2'h0);
    settle();
    `CHK(ch_pwr, 8'hFA)
    @(posedge ref_clk);
    recording <= 1'b1;
    wr(12'h1CC, 8'h00, 2'h0);
    settle();
    `CHK(ch_pwr, 8'h3A)
    wr(12'h1D4, 8'h40, 2'h0);
    wr(12'h1CC, 8'hFF, 2'h0);
    settle();
    `CHK(ch_pwr, 8'h3A)
    @(posedge ref_clk);
    recording <= 1'b0;
    settle();
    `CHK(ch_pwr, 8'hFA)
    rd(12'h240, 10'h2FA, 2'h0);
    $display("test power done");
    wr(12'h1CC, 8'h7A, 2'h0);
    wr(12'h200, 8'h11, 2'h0);
    wr(12'h204, 8'h22, 2'h0);
    settle();
    `CHK({ch_vol[63:48], ch_vol[7:0]}, 24'h1122C9)
    wr(12'h1B0, 8'h80, 2'h0);
    settle();
    `CHK(ch_vol, {8{8'h11}})
    $display("test gang done");
    wr(12'h3F0, 8'h5A, 2'h2);
    rd(12'h3F0, 8'h00, 2'h2);
    $display("test unmapped done");
    final_report();
  end

  initial begin
    repeat (5000) @(posedge ref_clk);
    bad_count++;
    final_report();
  end
endmodule // cfg_bank_bench
`default_nettype wire
